//--- src/dss_top.sv
// Decoder status supervisor: indicators, output source and timing selection
// Operation
// - References are ignored unless the frame-sync submodule is fitted.
// - 525 reference comes from its own input; 625 reference from another.
// - Configuration LED lit during initialisation, off once it completes.
// - 525 LED lights on 525 input; 625 LED on 625 input.
// - Decoding standard comes only from the manual setting.
// - Input and matching reference present: fault off, LED steady, locked video.
// - Input or reference mismatch: fault flashes, LED steady, input's own timing.
// - Reference missing: fault and standard LED flash, delay timing forced.
// - No input: fault flashes, both standard LEDs off, output black or frozen.
// - Submodule fitted, no video: timed black, or last field with autofreeze.
// - Sync mode, video without reference: decoded video on delay timing.
// - Delay mode with submodule: no reference needed, video, or black or last field with autofreeze.
// - No submodule: decoded video when valid, black when absent.
// - Filter LED lit while cross-colour filtering is applied.
// - Mode LED lit only in automatic detection mode.
// - Communication LED pulses on control-path traffic.
// - Standard setting picks 525 or 625, defaulting to 525.
//
// Our own choices: the plain strobed port and the placing of the registers.
module dss_top #(
  parameter int BLINK_HALF_CYC = dss_pkg::BLINK_HALF_CYC,
  parameter int COMMS_ACTIVITY_LED_PULSE_CYC = dss_pkg::COMMS_ACTIVITY_LED_PULSE_CYC,
  parameter int INIT_CYC = dss_pkg::INIT_CYC,
  parameter int QUAL_FIELDS = dss_pkg::QUAL_FIELDS
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Detection inputs from the video front end (asynchronous)
  input wire logic i_vid_present,
  input wire logic i_vid_is_625,
  input wire logic i_ref_525_present,
  input wire logic i_ref_625_present,
  input wire logic i_field,
  input wire logic i_fss_fitted,
  input wire logic i_filter_active,
  input wire logic i_comms_activity_led_traffic,
  // Indicators
  output logic o_power_good_led,
  output logic o_fault_led,
  output logic o_std_525_led,
  output logic o_std_625_led,
  output logic o_config_activity_led,
  output logic o_comms_activity_led,
  output logic o_filter_led,
  output logic o_mode_led,
  // Output selection
  output logic o_std_625,
  output logic [1:0] o_src,
  output logic [1:0] o_timing,
  // Interrupt
  output logic o_irq
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 8;

  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;

  // Front-end levels come from the video clock domain; two flops each
  assign sync_in = {
    i_vid_present,
    i_vid_is_625,
    i_ref_525_present,
    i_ref_625_present,
    i_field,
    i_fss_fitted,
    i_filter_active,
    i_comms_activity_led_traffic
  };

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= sync_in;
      sync_b <= sync_a;
    end
  end

  dss_pkg::dss_det_s raw;
  logic field_s;
  logic fss_s;
  logic filt_s;
  logic comms_activity_led_s;

  assign raw = sync_b[7:4];
  assign field_s = sync_b[3];
  assign fss_s = sync_b[2];
  assign filt_s = sync_b[1];
  assign comms_activity_led_s = sync_b[0];

  // ****************************************
  // Field qualification
  // ****************************************
  // One qualifier per detect level; field strobe edge paces them
  dss_pkg::dss_det_s qual;
  logic field_d;
  logic field_edge;

  assign field_edge = field_s & ~field_d;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_qual
      dss_qual #(
        .FIELDS(QUAL_FIELDS)
      ) u_qual (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_level(raw[g]),
        .i_field(field_edge),
        .o_level(qual[g])
      );
    end
  endgenerate

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic field_d;
    logic comms_activity_led_d;
    logic [4:0] ctrl;
    logic [dss_pkg::IRQ_W-1:0] irq_stat;
    logic [dss_pkg::IRQ_W-1:0] irq_en;
    logic [31:0] blink_cnt;
    logic blink;
    logic [31:0] init_cnt;
    logic init_done;
    logic [31:0] comms_activity_led_cnt;
    logic [7:0] rdata;
    dss_pkg::dss_led_s led;
    logic std_625;
    logic [1:0] src;
    logic [1:0] timing;
    logic fault_q;
    logic vid_q;
    logic ref_q;
  } dss_top_s;

  dss_top_s r;
  dss_top_s next_r;

  assign field_d = r.field_d;

  logic man_625;
  logic delay_mode;
  logic freeze_en;
  logic ref_ok;
  logic ref_other;
  logic std_match;
  logic fault_now;
  logic [dss_pkg::IRQ_W-1:0] ev;
  // Status word padded to the full bus width
  logic [7:0] status_word;

  always_comb begin
    man_625 = r.ctrl[dss_pkg::CTRL_STD_BIT];
    delay_mode = r.ctrl[dss_pkg::CTRL_DELAY_BIT];
    freeze_en = r.ctrl[dss_pkg::CTRL_FREEZE_BIT];
    // Reference chosen by detected standard from its own input
    ref_ok = fss_s & (qual.vid_is_625 ? qual.ref_625 : qual.ref_525);
    ref_other = fss_s & (qual.vid_is_625 ? qual.ref_525 : qual.ref_625);
    std_match = (qual.vid_is_625 == man_625);
    fault_now = 1'b0;
    ev = '0;
    status_word = {1'b0, r.init_done, fss_s, r.fault_q, qual};
    next_r = r;
    next_r.field_d = field_s;
    next_r.comms_activity_led_d = comms_activity_led_s;
    next_r.rdata = 8'h00;

    // Common blink timebase
    // One counter for every flashing LED keeps fault and standard in phase
    if (r.blink_cnt >= 32'(BLINK_HALF_CYC - 1)) begin
      next_r.blink_cnt = 32'h0;
      next_r.blink = ~r.blink;
    end else begin
      next_r.blink_cnt = r.blink_cnt + 32'h1;
    end

    // Initialisation window
    // Counter stops once done, so init never restarts without a reset
    if (!r.init_done) begin
      if (r.init_cnt >= 32'(INIT_CYC - 1)) begin
        next_r.init_done = 1'b1;
        ev[dss_pkg::IRQ_INIT_BIT] = 1'b1;
      end else begin
        next_r.init_cnt = r.init_cnt + 32'h1;
      end
    end
    next_r.led.config_activity_led = ~r.init_done;

    // Communication stretch
    // Short bursts are stretched so they stay visible on the panel
    if (comms_activity_led_s && !r.comms_activity_led_d) begin
      next_r.comms_activity_led_cnt = 32'(COMMS_ACTIVITY_LED_PULSE_CYC);
    end else if (r.comms_activity_led_cnt != 32'h0) begin
      next_r.comms_activity_led_cnt = r.comms_activity_led_cnt - 32'h1;
    end
    next_r.led.comms_activity_led = (r.comms_activity_led_cnt != 32'h0);
    next_r.led.filter = filt_s;
    next_r.led.mode = r.ctrl[dss_pkg::CTRL_AUTO_BIT];

    // Status decision
    next_r.std_625 = man_625;
    if (!qual.vid_present) begin
      fault_now = 1'b1;
      next_r.led.std_525 = 1'b0;
      next_r.led.std_625 = 1'b0;
      if (fss_s && freeze_en) begin
        next_r.src = dss_pkg::DSS_SRC_FREEZE;
      end else begin
        next_r.src = dss_pkg::DSS_SRC_BLACK;
      end
      if (!fss_s || delay_mode) begin
        next_r.timing = dss_pkg::DSS_TIM_DELAY;
      end else begin
        next_r.timing = dss_pkg::DSS_TIM_LOCKED;
      end
    end else begin
      next_r.src = dss_pkg::DSS_SRC_VIDEO;
      // One standard LED follows the detected input
      if (qual.vid_is_625) begin
        next_r.led.std_525 = 1'b0;
        next_r.led.std_625 = 1'b1;
      end else begin
        next_r.led.std_525 = 1'b1;
        next_r.led.std_625 = 1'b0;
      end
      if (!fss_s) begin
        // No submodule: timing from input only
        next_r.timing = dss_pkg::DSS_TIM_INPUT;
        fault_now = ~std_match;
      end else if (!std_match || (ref_other && !ref_ok)) begin
        fault_now = 1'b1;
        next_r.timing = dss_pkg::DSS_TIM_INPUT;
      end else if (delay_mode) begin
        next_r.timing = dss_pkg::DSS_TIM_DELAY;
      end else if (!ref_ok) begin
        fault_now = 1'b1;
        // Matching reference missing: flash standard LED too
        if (qual.vid_is_625) begin
          next_r.led.std_625 = r.blink;
        end else begin
          next_r.led.std_525 = r.blink;
        end
        next_r.timing = dss_pkg::DSS_TIM_DELAY;
      end else begin
        next_r.timing = dss_pkg::DSS_TIM_LOCKED;
      end
    end
    next_r.led.fault = fault_now & r.blink;
    next_r.fault_q = fault_now;
    next_r.vid_q = qual.vid_present;
    next_r.ref_q = ref_ok;
    ev[dss_pkg::IRQ_FAULT_BIT] = fault_now & ~r.fault_q;
    ev[dss_pkg::IRQ_VID_BIT] = qual.vid_present ^ r.vid_q;
    ev[dss_pkg::IRQ_REF_BIT] = ref_ok ^ r.ref_q;

    // Register access; a new event wins over its clear
    if (i_wr) begin
      case (i_addr)
        dss_pkg::ADDR_CTRL: begin
          next_r.ctrl = i_wdata[4:0];
        end
        dss_pkg::ADDR_IRQ_CLR: begin
          next_r.irq_stat = r.irq_stat & ~i_wdata[dss_pkg::IRQ_W-1:0];
        end
        dss_pkg::ADDR_IRQ_EN: begin
          next_r.irq_en = i_wdata[dss_pkg::IRQ_W-1:0];
        end
        default: begin
          next_r.ctrl = r.ctrl;
        end
      endcase
    end
    next_r.irq_stat = next_r.irq_stat | ev;
    if (i_rd) begin
      case (i_addr)
        dss_pkg::ADDR_CTRL: begin
          next_r.rdata = {3'h0, r.ctrl};
        end
        dss_pkg::ADDR_STATUS: begin
          next_r.rdata = status_word;
        end
        dss_pkg::ADDR_IRQ_STAT: begin
          next_r.rdata = {4'h0, r.irq_stat};
        end
        dss_pkg::ADDR_IRQ_EN: begin
          next_r.rdata = {4'h0, r.irq_en};
        end
        default: begin
          next_r.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      r <= '0;
      r.ctrl <= dss_pkg::CTRL_RESET;
      // Config LED lit from the very first cycle of initialisation
      r.led.config_activity_led <= 1'b1;
      // Black until the detectors have qualified an input
      r.src <= dss_pkg::DSS_SRC_BLACK;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_rdata = r.rdata;
  // Lit whenever the logic is powered and clocked
  assign o_power_good_led = 1'b1;
  assign o_fault_led = r.led.fault;
  assign o_std_525_led = r.led.std_525;
  assign o_std_625_led = r.led.std_625;
  assign o_config_activity_led = r.led.config_activity_led;
  assign o_comms_activity_led = r.led.comms_activity_led;
  assign o_filter_led = r.led.filter;
  assign o_mode_led = r.led.mode;
  assign o_std_625 = r.std_625;
  assign o_src = r.src;
  assign o_timing = r.timing;
  assign o_irq = |(r.irq_stat & r.irq_en);

endmodule : dss_top

//--- src/dss_pkg.sv
// Package: constants and carrier types of the decoder status supervisor
package dss_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 40000000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int COMMS_ACTIVITY_LED_PULSE_MS = 50;
  localparam int COMMS_ACTIVITY_LED_PULSE_CYC = (CLK_HZ / 1000) * COMMS_ACTIVITY_LED_PULSE_MS;
  localparam int INIT_MS = 100;
  localparam int INIT_CYC = (CLK_HZ / 1000) * INIT_MS;
  localparam int QUAL_FIELDS = 4;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h4;

  // CTRL fields
  localparam int CTRL_STD_BIT = 0;
  localparam int CTRL_DELAY_BIT = 1;
  localparam int CTRL_FREEZE_BIT = 2;
  localparam int CTRL_AUTO_BIT = 3;
  localparam int CTRL_FILTER_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Interrupt event bits
  localparam int IRQ_W = 4;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_VID_BIT = 1;
  localparam int IRQ_REF_BIT = 2;
  localparam int IRQ_INIT_BIT = 3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    DSS_SRC_VIDEO = 2'b00,
    DSS_SRC_BLACK = 2'b01,
    DSS_SRC_FREEZE = 2'b10
  } dss_src_e;

  typedef enum logic [1:0] {
    DSS_TIM_LOCKED = 2'b00,
    DSS_TIM_FREERUN = 2'b01,
    DSS_TIM_DELAY = 2'b10,
    DSS_TIM_INPUT = 2'b11
  } dss_tim_e;

  typedef struct packed {
    logic fault;
    logic std_525;
    logic std_625;
    logic config_activity_led;
    logic comms_activity_led;
    logic filter;
    logic mode;
  } dss_led_s;

  typedef struct packed {
    logic vid_present;
    logic vid_is_625;
    logic ref_525;
    logic ref_625;
  } dss_det_s;

endpackage : dss_pkg

//--- src/dss_qual.sv
// Field-count qualifier: a level must hold for several fields before it is accepted
module dss_qual #(
  parameter int FIELDS = dss_pkg::QUAL_FIELDS
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Raw level and field strobe
  input wire logic i_level,
  input wire logic i_field,
  // Qualified level
  output logic o_level
);

  typedef struct packed {
    logic [7:0] cnt;
    logic q;
  } dss_qual_s;

  dss_qual_s r;
  dss_qual_s next_r;

  always_comb begin
    next_r = r;
    if (i_level == r.q) begin
      next_r.cnt = 8'h00;
    end else if (i_field) begin
      if (r.cnt == 8'(FIELDS - 1)) begin
        next_r.q = i_level;
        next_r.cnt = 8'h00;
      end else begin
        next_r.cnt = r.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_level = r.q;

endmodule : dss_qual

//--- test/dss_top_chk.sv
// Checker: port-level properties of the decoder status supervisor
module dss_top_chk #(
  parameter int INIT_CYC = 5
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Inputs watched
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_fss_fitted,
  input wire logic i_filter_active,
  input wire logic i_comms_activity_led_traffic,
  // Outputs watched
  input wire logic o_fault_led,
  input wire logic o_std_525_led,
  input wire logic o_std_625_led,
  input wire logic o_config_activity_led,
  input wire logic o_comms_activity_led,
  input wire logic o_filter_led,
  input wire logic o_mode_led,
  input wire logic o_std_625,
  input wire logic [1:0] o_src,
  input wire logic [1:0] o_timing
);
  // ****************************************
  // Helpers
  // ****************************************
  logic ctrl_wr;
  logic [15:0] up_cnt;
  logic [5:0] nofss_cnt;
  logic mode_exp;
  logic std_exp;
  assign ctrl_wr = i_wr && (i_addr == dss_pkg::ADDR_CTRL);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      up_cnt <= 16'h0000;
      nofss_cnt <= 6'h00;
      mode_exp <= 1'b0;
      std_exp <= 1'b0;
    end else begin
      up_cnt <= (up_cnt == 16'hFFFF) ? up_cnt : up_cnt + 16'h0001;
      nofss_cnt <= i_fss_fitted ? 6'h00 : ((nofss_cnt == 6'h3F) ? nofss_cnt : nofss_cnt + 6'h01);
      mode_exp <= ctrl_wr ? i_wdata[3] : mode_exp;
      std_exp <= ctrl_wr ? i_wdata[0] : std_exp;
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ****************************************
  // Properties
  // ****************************************
  sequence s_ctrl_quiet;
    ctrl_wr ##1 !ctrl_wr [*3];
  endsequence
  sequence s_comms_activity_led_edge;
    !i_comms_activity_led_traffic ##1 i_comms_activity_led_traffic;
  endsequence
  property p_init_on;
    up_cnt < INIT_CYC |-> o_config_activity_led;
  endproperty
  property p_init_off;
    up_cnt > INIT_CYC + 2 |-> !o_config_activity_led;
  endproperty
  property p_std_src;
    $changed(o_std_625) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
  endproperty
  property p_ctrl_leds;
    s_ctrl_quiet |-> (o_mode_led == mode_exp) && (o_std_625 == std_exp);
  endproperty
  property p_comms_activity_led;
    s_comms_activity_led_edge |-> ##[1:6] o_comms_activity_led;
  endproperty
  property p_filt_on;
    i_filter_active [*6] |-> o_filter_led;
  endproperty
  property p_filt_off;
    !i_filter_active [*6] |-> !o_filter_led;
  endproperty
  property p_no_fss;
    nofss_cnt == 6'h3F |-> o_timing != dss_pkg::DSS_TIM_LOCKED;
  endproperty
  property p_black;
    o_src != dss_pkg::DSS_SRC_VIDEO |-> !o_std_525_led && !o_std_625_led;
  endproperty
  property p_phase;
    $fell(o_std_525_led) && !o_std_625_led && o_src == dss_pkg::DSS_SRC_VIDEO && $stable(o_src)
      |-> !o_fault_led;
  endproperty
  a_init_on: assert property (p_init_on)
    else $error("config led dark during init");
  a_init_off: assert property (p_init_off)
    else $error("config led lit after init");
  a_std_src: assert property (p_std_src)
    else $error("standard changed without control write");
  a_ctrl_leds: assert property (p_ctrl_leds)
    else $error("mode led or standard not as written");
  a_comms_activity_led: assert property (p_comms_activity_led)
    else $error("comms led missed traffic");
  a_filt_on: assert property (p_filt_on)
    else $error("filter led dark while filtering");
  a_filt_off: assert property (p_filt_off)
    else $error("filter led lit while idle");
  a_no_fss: assert property (p_no_fss)
    else $error("locked timing without submodule");
  a_black: assert property (p_black)
    else $error("standard led lit with no video");
  a_phase: assert property (p_phase)
    else $error("fault and standard blink out of phase");
endmodule : dss_top_chk

bind dss_top dss_top_chk #(.INIT_CYC(INIT_CYC)) u_chk (.i_sys_clk, .i_rst_n, .i_addr, .i_wdata,
  .i_wr, .i_fss_fitted, .i_filter_active, .i_comms_activity_led_traffic, .o_fault_led, .o_std_525_led,
  .o_std_625_led, .o_config_activity_led, .o_comms_activity_led, .o_filter_led, .o_mode_led,
  .o_std_625, .o_src, .o_timing);

//--- test/dss_src_model.sv
// Partner: composite source and black-burst references with a field strobe
module dss_src_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Scenario controls
  input wire logic i_vid_on,
  input wire logic i_vid_625,
  input wire logic i_ref5_on,
  input wire logic i_ref6_on,
  // Front-end levels
  output logic o_vid_present,
  output logic o_vid_is_625,
  output logic o_ref_525,
  output logic o_ref_625,
  output logic o_field
);
  logic [2:0] phase;
  logic churn;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      phase <= 3'h0;
      churn <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      churn <= ~churn;
    end
  end
  assign o_field = (phase == 3'h7);
  assign o_vid_present = i_vid_on;
  // Standard line is meaningless without video, so it churns
  assign o_vid_is_625 = i_vid_on ? i_vid_625 : churn;
  assign o_ref_525 = i_ref5_on;
  assign o_ref_625 = i_ref6_on;
endmodule : dss_src_model

//--- test/dss_top_bench.sv
// Bench: corner and random front-end conditions through the supervisor
module dss_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic i_fss_fitted = 1'b0, i_filter_active = 1'b0, i_comms_activity_led_traffic = 1'b0;
  logic vid_on = 1'b0, vid_625 = 1'b0, ref5 = 1'b0, ref6 = 1'b0;
  logic vp, v625, r5, r6, fld, power_good_led, o_fault_led, o_std_525_led, o_std_625_led;
  logic o_config_activity_led, o_comms_activity_led, o_filter_led, o_mode_led, o_std_625, o_irq;
  logic [1:0] o_src, o_timing;
  logic [31:0] seed = 32'h0000000A;
  int failures = 0, cmp_count = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  dss_src_model u_src (.i_sys_clk, .i_rst_n, .i_vid_on(vid_on), .i_vid_625(vid_625),
    .i_ref5_on(ref5), .i_ref6_on(ref6), .o_vid_present(vp), .o_vid_is_625(v625),
    .o_ref_525(r5), .o_ref_625(r6), .o_field(fld));
  dss_top #(.BLINK_HALF_CYC(4), .COMMS_ACTIVITY_LED_PULSE_CYC(3), .INIT_CYC(5), .QUAL_FIELDS(2)) dut (
    .i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_vid_present(vp),
    .i_vid_is_625(v625), .i_ref_525_present(r5), .i_ref_625_present(r6), .i_field(fld),
    .i_fss_fitted, .i_filter_active, .i_comms_activity_led_traffic, .o_power_good_led(power_good_led), .o_fault_led,
    .o_std_525_led, .o_std_625_led, .o_config_activity_led, .o_comms_activity_led,
    .o_filter_led, .o_mode_led, .o_std_625, .o_src, .o_timing, .o_irq);
  // ****************************************
  // Tasks
  // ****************************************
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Packs {src, timing, fault, led525, led625}; led codes 0 off, 1 on, 2 flash
  function automatic logic [9:0] exp_out(input logic [4:0] e, input logic [2:0] c);
    logic fss, v, s6, a, b, my, oth;
    logic [3:0] on;
    {fss, v, s6, a, b} = e;
    my = s6 ? b : a;
    oth = s6 ? a : b;
    on = s6 ? 4'h1 : 4'h4;
    if (!v) return {(fss && c[2]) ? 2'h2 : 2'h1, (!fss || c[1]) ? 2'h2 : 2'h0, 2'h2, 4'h0};
    if (!fss) return {2'h0, 2'h3, (s6 != c[0]) ? 2'h2 : 2'h0, on};
    if (s6 != c[0] || (!my && oth)) return {2'h0, 2'h3, 2'h2, on};
    if (c[1]) return {2'h0, 2'h2, 2'h0, on};
    if (!my) return {2'h0, 2'h2, 2'h2, on << 1};
    return {2'h0, 2'h0, 2'h0, on};
  endfunction : exp_out
  function automatic logic [1:0] md(input int n);
    return (n == 0) ? 2'h0 : ((n == 16) ? 2'h1 : 2'h2);
  endfunction : md
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("compares=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd
  // Qualification spans a few fields, so wait beyond the first match
  task automatic settle(input logic [9:0] x);
    int k;
    k = 0;
    while ({o_src, o_timing} !== x[9:6] && k < 400) begin
      @(posedge i_sys_clk);
      k++;
    end
    if (k == 400) begin
      failures++;
      conclude();
    end
    repeat (32) @(posedge i_sys_clk);
  endtask : settle
  task automatic watch(output logic [9:0] got);
    int nf, n5, n6;
    nf = 0;
    n5 = 0;
    n6 = 0;
    for (int k = 0; k < 16; k++) begin
      @(posedge i_sys_clk);
      #1;
      nf += (o_fault_led === 1'b1);
      n5 += (o_std_525_led === 1'b1);
      n6 += (o_std_625_led === 1'b1);
    end
    got = {o_src, o_timing, md(nf), md(n5), md(n6)};
  endtask : watch
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    logic [4:0] e;
    logic [2:0] c;
    logic [9:0] x, got;
    logic [31:0] r;
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(dss_pkg::ADDR_CTRL, d);
    chk({d, o_std_625, o_config_activity_led}, 10'h001);
    chk(power_good_led, 1'b1);
    rd(4'hF, d);
    chk(d, 8'h00);
    wr(dss_pkg::ADDR_IRQ_EN, 8'h0F);
    for (int i = 0; i < 40; i++) begin
      r = xs();
      e = (i < 16) ? {1'b1, i[3:0]} : r[4:0];
      c = r[10:8];
      wr(dss_pkg::ADDR_CTRL, {4'h0, r[11], c});
      {i_fss_fitted, vid_on, vid_625, ref5, ref6} <= e;
      i_filter_active <= r[12];
      i_comms_activity_led_traffic <= r[13];
      x = exp_out(e, c);
      settle(x);
      watch(got);
      chk(got, x);
      chk({o_filter_led, o_mode_led, o_std_625, o_config_activity_led}, {r[12], r[11], c[0], 1'b0});
      rd(dss_pkg::ADDR_CTRL, d);
      chk(d, {4'h0, r[11], c});
    end
    rd(dss_pkg::ADDR_IRQ_STAT, d);
    chk(d[3], 1'b1);
    wr(dss_pkg::ADDR_CTRL, 8'h00);
    {i_fss_fitted, vid_on, vid_625, ref5, ref6} <= 5'h1A;
    settle(exp_out(5'h1A, 3'h0));
    rd(dss_pkg::ADDR_STATUS, d);
    chk(d, 8'h6A);
    wr(dss_pkg::ADDR_IRQ_CLR, 8'h0F);
    rd(dss_pkg::ADDR_IRQ_STAT, d);
    chk({d[1], o_irq}, 2'h0);
    @(posedge i_sys_clk);
    vid_on <= 1'b0;
    settle(exp_out(5'h12, 3'h0));
    rd(dss_pkg::ADDR_IRQ_STAT, d);
    chk({d[1], o_irq}, 2'h3);
    wr(dss_pkg::ADDR_IRQ_EN, 8'h00);
    #1;
    chk(o_irq, 1'b0);
    wr(dss_pkg::ADDR_IRQ_CLR, 8'h0F);
    wr(dss_pkg::ADDR_IRQ_STAT, 8'hFF);
    rd(dss_pkg::ADDR_IRQ_STAT, d);
    chk(d[1], 1'b0);
    conclude();
  end
endmodule : dss_top_bench
